/* design/idread_host.v */
/*
 * Host controller that reads identifier words from a parallel x16 flash,
 * either with the high-voltage level on address bit nine or through the
 * in-system identifier command sequence.
 * Assumes a 20 MHz clock, an external level shifter that applies the high
 * voltage when HV_EN_OUT is high, and a data bus resolved outside.
 */
// Summary of operation
// - Command sequence enters mode without high voltage
// - Bank select on third command write
// - Sector select on high bits for protection
// - Secured-silicon poll uses bank in range
`timescale 1ns/1ps
`include "idread_map.vh"

module idread_host #(
  parameter AW = 22,
  parameter DW = 16,
  parameter [AW-1:0] SECSI_BANK = 22'h004000
) (
  // Clock, reset and enable.
  input wire CLOCK_IN,
  input wire SYS_RST_IN,
  input wire CLK_EN_IN,
  // Request from the user side.
  input wire REQ_IN,
  input wire USE_CMD_IN,
  input wire [3:0] SEL_IN,
  input wire [AW-1:0] UPPER_ADDR_IN,
  input wire EXIT_IN,
  // Answer to the user side.
  output reg BUSY_OUT,
  output reg DONE_OUT,
  output reg [DW-1:0] WORD_OUT,
  output reg PROTECTED_OUT,
  output reg FACTORY_LOCK_OUT,
  output reg CUSTOMER_LOCK_OUT,
  // Flash pins.
  output reg [AW-1:0] ADDR_OUT,
  output reg [DW-1:0] DQ_OUT,
  output reg DQ_OE_OUT,
  input wire [DW-1:0] DQ_IN,
  output reg LOWER_DIE_ENABLE_N_OUT,
  output reg OE_N_OUT,
  output reg WE_N_OUT,
  output reg HV_EN_OUT
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_WSET = 4'h1;
  localparam [3:0] ST_WSTB = 4'h2;
  localparam [3:0] ST_WREL = 4'h3;
  localparam [3:0] ST_RSET = 4'h4;
  localparam [3:0] ST_RWAIT = 4'h5;
  localparam [3:0] ST_DONE = 4'h6;
  localparam [7:0] STB_CYC = (`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [7:0] ACC_CYC = (`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS + 2;
  // Third command address; only its low twelve bits ride under the bank.
  localparam [AW-1:0] CMD_A3_W = `CMD_A3;
  // Last word address of the window for secured-silicon polling.
  localparam [AW-1:0] SECSI_TOP = 22'h03FFFF;

  // ==========================================================
  // Read address builder.
  // Low four bits pick the word; bits 7 and 6 low; don't-cares low.
  function [AW-1:0] rd_addr;
    input [3:0] sel;
    input [AW-1:0] upper;
    input hv;
    reg [AW-1:0] a;
    begin
      a = {upper[AW-1:12], 12'h000};
      // A bank outside the polling window is replaced by the default one.
      if (sel == `ID_SEL_SECSI &&
          (upper < SECSI_BANK || upper > SECSI_TOP))
        a = SECSI_BANK;
      a[3:0] = sel;
      a[`ADDR_HV_BIT] = hv;
      rd_addr = a;
    end
  endfunction

  reg [3:0] st_r;
  reg [7:0] cnt_r;
  reg [1:0] step_r;
  reg in_mode_r;
  reg exit_r;
  reg [3:0] sel_r;
  reg [AW-1:0] up_r;
  reg [DW-1:0] dq_s1_r;
  reg [DW-1:0] dq_s2_r;

  // Two-flop synchroniser for the data lines.
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else if (CLK_EN_IN) begin
      dq_s1_r <= DQ_IN;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ==========================================================
  // Sequencer: command writes, then an identifier read.
  always @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      step_r <= 2'h0;
      in_mode_r <= 1'b0;
      exit_r <= 1'b0;
      sel_r <= 4'h0;
      up_r <= 22'h000000;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      WORD_OUT <= 16'h0000;
      PROTECTED_OUT <= 1'b0;
      FACTORY_LOCK_OUT <= 1'b0;
      CUSTOMER_LOCK_OUT <= 1'b0;
      ADDR_OUT <= 22'h000000;
      DQ_OUT <= 16'h0000;
      DQ_OE_OUT <= 1'b0;
      LOWER_DIE_ENABLE_N_OUT <= 1'b1;
      OE_N_OUT <= 1'b1;
      WE_N_OUT <= 1'b1;
      HV_EN_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      DONE_OUT <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (REQ_IN) begin
            BUSY_OUT <= 1'b1;
            sel_r <= SEL_IN;
            up_r <= UPPER_ADDR_IN;
            exit_r <= EXIT_IN;
            step_r <= 2'h0;
            if (EXIT_IN || (USE_CMD_IN && !in_mode_r))
              st_r <= ST_WSET;
            else
              st_r <= ST_RSET;
            HV_EN_OUT <= !USE_CMD_IN && !EXIT_IN;
          end
        end
        ST_WSET: begin
          // Present the address and data of the next command write.
          LOWER_DIE_ENABLE_N_OUT <= 1'b0;
          DQ_OE_OUT <= 1'b1;
          if (exit_r) begin
            ADDR_OUT <= {AW{1'b0}};
            DQ_OUT <= `CMD_EXIT;
          end else if (step_r == 2'h0) begin
            ADDR_OUT <= `CMD_A1;
            DQ_OUT <= `CMD_D1;
          end else if (step_r == 2'h1) begin
            ADDR_OUT <= `CMD_A2;
            DQ_OUT <= `CMD_D2;
          end else begin
            // Bank select rides on the upper bits of the third write.
            ADDR_OUT <= {up_r[AW-1:12], CMD_A3_W[11:0]};
            DQ_OUT <= `CMD_D3;
          end
          cnt_r <= STB_CYC;
          st_r <= ST_WSTB;
        end
        ST_WSTB: begin
          WE_N_OUT <= 1'b0;
          if (cnt_r == 8'h00)
            st_r <= ST_WREL;
          else
            cnt_r <= cnt_r - 8'h01;
        end
        ST_WREL: begin
          // Raise only the write strobe: the device latches on this edge,
          // so enable, address and data stay one more cycle for hold.
          WE_N_OUT <= 1'b1;
          if (exit_r) begin
            in_mode_r <= 1'b0;
            st_r <= ST_DONE;
          end else if (step_r == 2'h2) begin
            in_mode_r <= 1'b1;
            st_r <= ST_RSET;
          end else begin
            step_r <= step_r + 2'h1;
            st_r <= ST_WSET;
          end
        end
        ST_RSET: begin
          // Enables low, write high, identifier address applied.
          ADDR_OUT <= rd_addr(sel_r, up_r, 1'b0);
          LOWER_DIE_ENABLE_N_OUT <= 1'b0;
          OE_N_OUT <= 1'b0;
          WE_N_OUT <= 1'b1;
          DQ_OE_OUT <= 1'b0;
          cnt_r <= ACC_CYC;
          st_r <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if (cnt_r == 8'h00) begin
            WORD_OUT <= dq_s2_r;
            if (sel_r == `ID_SEL_PROT)
              PROTECTED_OUT <= (dq_s2_r == `PROT_SET_WORD);
            if (sel_r == `ID_SEL_SECSI) begin
              FACTORY_LOCK_OUT <= dq_s2_r[`SECSI_FACTORY_BIT];
              CUSTOMER_LOCK_OUT <= dq_s2_r[`SECSI_CUSTOMER_BIT];
            end
            OE_N_OUT <= 1'b1;
            LOWER_DIE_ENABLE_N_OUT <= 1'b1;
            st_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_DONE: begin
          // Let go of the enable and the data lines held after a write.
          LOWER_DIE_ENABLE_N_OUT <= 1'b1;
          DQ_OE_OUT <= 1'b0;
          HV_EN_OUT <= 1'b0;
          BUSY_OUT <= 1'b0;
          DONE_OUT <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* dv/idflash_model.sv */
/* Behavioural flash answering identifier reads.
   Assumes the pins of idread_host, no clock. */
`timescale 1ns/1ps
module idflash_model #(
  parameter [63:0] IDS = 64'h1234_5678_9ABC_DEF0, // Arbitrary codes.
  parameter [9:0] PROT_SECT = 10'h001
) (
  // Pins from the host, and the lock bits from the bench.
  input wire [21:0] addr_in,
  input wire [15:0] dq_in,
  input wire ce_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire hv_in,
  input wire [1:0] lock_in,
  // Data back to the host.
  output wire [15:0] dq_out
);
  reg [1:0] step_r = 2'h0;
  reg mode_r = 1'h0;
  reg [2:0] bank_r = 3'h0;
  reg [15:0] wd;
  reg [15:0] last_r = 16'h0;
  wire rd = !ce_n_in && !oe_n_in && we_n_in;
  wire id = hv_in || mode_r && addr_in[21:19] == bank_r;
  wire [15:0] val = id && addr_in[7:6] == 2'h0 ? wd : ~addr_in[15:0];
  // ==========================================
  // Command writes are taken as write enable rises.
  always @(posedge we_n_in) begin
    if (dq_in[7:0] == 8'hF0) mode_r <= 1'h0;
    case ({step_r, addr_in[10:0], dq_in[7:0]})
      {2'h0, 11'h555, 8'hAA}: step_r <= 2'h1;
      {2'h1, 11'h2AA, 8'h55}: step_r <= 2'h2;
      {2'h2, 11'h555, 8'h90}: begin
        mode_r <= 1'h1;
        bank_r <= addr_in[21:19];
        step_r <= 2'h0;
      end
      default: step_r <= 2'h0;
    endcase
  end
  // Word picked by the four low bits only.
  always @* begin
    case (addr_in[3:0])
      4'h0: wd = IDS[63:48];
      4'h1: wd = IDS[47:32];
      4'hE: wd = IDS[31:16];
      4'hF: wd = IDS[15:0];
      4'h2: wd = {15'h0, addr_in[21:12] == PROT_SECT};
      4'h3: wd = {8'h0, lock_in[1], &lock_in, 6'h0};
      default: wd = 16'h0;
    endcase
  end
  // Released bus shows the inverse of the last word.
  always @* if (rd) last_r = val;
  assign dq_out = rd ? val : ~last_r;
endmodule

/* dv/idread_chk.sv */
/* Assertions on the identifier host pins.
   Assumes it is bound onto idread_host, one clock domain. */
`timescale 1ns/1ps
module idread_chk (
  // Clock, reset and request.
  input wire CLOCK_IN,
  input wire SYS_RST_IN,
  input wire REQ_IN,
  input wire USE_CMD_IN,
  input wire EXIT_IN,
  // Status and flash pins.
  input wire BUSY_OUT,
  input wire DONE_OUT,
  input wire [21:0] ADDR_OUT,
  input wire DQ_OE_OUT,
  input wire LOWER_DIE_ENABLE_N_OUT,
  input wire OE_N_OUT,
  input wire WE_N_OUT,
  input wire HV_EN_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================
  // Pin relations of reads and command writes.
  sequence hv_go;
    REQ_IN && !USE_CMD_IN && !EXIT_IN && !BUSY_OUT && !DONE_OUT;
  endsequence
  sequence hv_walk;
    ##1 BUSY_OUT && HV_EN_OUT ##1 !OE_N_OUT ##6 DONE_OUT;
  endsequence
  a_hv_walk: assert property (hv_go |-> hv_walk)
    else $error("high voltage read walk broken");
  a_read_strobes: assert property (!OE_N_OUT |->
    !LOWER_DIE_ENABLE_N_OUT && WE_N_OUT && !DQ_OE_OUT) else $error("read pins");
  a_low_bits_fixed: assert property ($fell(OE_N_OUT) |->
    ADDR_OUT[9:6] == 4'h0) else $error("address bits 9 to 6 not low");
  a_write_no_hv: assert property (!WE_N_OUT |->
    !HV_EN_OUT && OE_N_OUT && DQ_OE_OUT) else $error("write pins");
  a_write_width: assert property ($fell(WE_N_OUT) |->
    !WE_N_OUT [*3] ##1 WE_N_OUT) else $error("write strobe width");
  a_secure_bank: assert property ($fell(OE_N_OUT) &&
    ADDR_OUT[3:0] == 4'h3 |-> ADDR_OUT inside {[22'h004000:22'h03FFFF]})
    else $error("secured read bank out of range");
  a_done_release: assert property ($rose(DONE_OUT) |->
    !HV_EN_OUT && OE_N_OUT && !BUSY_OUT) else $error("done pins");
  a_done_pulse: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");
endmodule
bind idread_host idread_chk idread_chk_i (.*);

/* dv/testbench.sv */
/* Self-checking bench of idread_host against idflash_model.
   Assumes a 50 ns clock and inputs changed on the falling edge. */
`timescale 1ns/1ps
module testbench;
  reg CLOCK_IN, SYS_RST_IN = 1'h1, CLK_EN_IN = 1'h1, REQ_IN = 1'h0;
  reg USE_CMD_IN = 1'h0, EXIT_IN = 1'h0;
  reg [3:0] SEL_IN = 4'h0;
  reg [21:0] UPPER_ADDR_IN = 22'h0;
  reg [1:0] lock = 2'h0;
  wire BUSY_OUT, DONE_OUT, PROTECTED_OUT, FACTORY_LOCK_OUT, CUSTOMER_LOCK_OUT;
  wire DQ_OE_OUT, LOWER_DIE_ENABLE_N_OUT, OE_N_OUT, WE_N_OUT, HV_EN_OUT;
  wire [15:0] WORD_OUT, DQ_OUT, DQ_IN, dq_dev;
  wire [21:0] ADDR_OUT;
  integer bad_count = 0, n_tests = 0, i;
  localparam [63:0] IDS = 64'h0A5C_1B01_2C02_3D03;
  localparam [9:0] PS = 10'h2A5;
  // ==========================================
  // Host, flash model and the shared data wire.
  assign DQ_IN = DQ_OE_OUT ? DQ_OUT : dq_dev;
  idread_host idread_host_i (.*);
  idflash_model #(.IDS(IDS), .PROT_SECT(PS)) idflash_model_i (
    .addr_in(ADDR_OUT), .dq_in(DQ_IN), .ce_n_in(LOWER_DIE_ENABLE_N_OUT),
    .oe_n_in(OE_N_OUT), .we_n_in(WE_N_OUT), .hv_in(HV_EN_OUT),
    .lock_in(lock), .dq_out(dq_dev));
  // Clock generator.
  initial begin
    CLOCK_IN = 1'h0;
    forever #25 CLOCK_IN = ~CLOCK_IN;
  end
  task close_out;
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request, then a bounded wait for the done pulse.
  task req(input c, input x, input [3:0] s, input [21:0] u);
    integer k;
    @(negedge CLOCK_IN);
    {USE_CMD_IN, EXIT_IN, SEL_IN, UPPER_ADDR_IN, REQ_IN} = {c, x, s, u, 1'h1};
    @(negedge CLOCK_IN);
    REQ_IN = 1'h0;
    for (k = 0; k < 60 && DONE_OUT !== 1'h1; k = k + 1) @(negedge CLOCK_IN);
    chk("done", 16'h1, {15'h0, DONE_OUT});
  endtask
  task t_hv_ids;
    for (i = 0; i < 4; i = i + 1) begin
      req(1'h0, 1'h0, {{3{i[1]}}, i[0]}, 22'h3FF000);
      chk("id", IDS[63 - 16 * i -: 16], WORD_OUT);
    end
  endtask
  task t_prot;
    req(1'h0, 1'h0, 4'h2, {PS, 12'h0});
    chk("prot", 16'h1, {WORD_OUT[15:1], PROTECTED_OUT});
    req(1'h0, 1'h0, 4'h2, {PS ^ 10'h1, 12'h0});
    chk("unprot", 16'h0, {WORD_OUT[15:1], PROTECTED_OUT});
  endtask
  task t_secure;
    for (i = 0; i < 4; i = i + 1) begin
      lock = i[1:0];
      req(1'h0, 1'h0, 4'h3, 22'h0);
      chk("lock", {i[1], &i[1:0]}, {FACTORY_LOCK_OUT, CUSTOMER_LOCK_OUT});
      chk("sword", {8'h0, i[1], &i[1:0], 6'h0}, WORD_OUT);
    end
  endtask
  task t_cmd;
    req(1'h1, 1'h0, 4'h0, {PS, 12'h0});
    chk("cmdmfr", IDS[63:48], WORD_OUT);
    req(1'h1, 1'h0, 4'h2, {PS, 12'h0});
    chk("cmdprot", 16'h1, WORD_OUT);
    req(1'h1, 1'h1, 4'h0, 22'h0);
    req(1'h1, 1'h0, 4'hE, 22'h05F000);
    chk("cmddev2", IDS[31:16], WORD_OUT);
    req(1'h1, 1'h0, 4'h1, {PS, 12'h0});
    chk("cmdother", ~{PS[3:0], 12'h001}, WORD_OUT);
  endtask
  // Main sequence after two reset cycles.
  initial begin
    repeat (2) @(negedge CLOCK_IN);
    SYS_RST_IN = 1'h0;
    t_hv_ids;
    t_prot;
    t_secure;
    t_cmd;
    close_out;
  end
  // Watchdog well beyond the expected run.
  initial begin
    #200000;
    bad_count = bad_count + 1;
    close_out;
  end
endmodule

/* pkg/idread_map.vh */
/*
 * Constants for the identifier readout host controller: address bit
 * positions, identifier word selects, command sequence words and timing.
 * Assumes a parallel x16 flash with a 22-bit word address.
 */
`ifndef IDREAD_MAP_VH
`define IDREAD_MAP_VH

// ==========================================================
// Identifier word selects on the four lowest address bits.
`define ID_SEL_MFR 4'h0
`define ID_SEL_DEV1 4'h1
`define ID_SEL_DEV2 4'hE
`define ID_SEL_DEV3 4'hF
`define ID_SEL_PROT 4'h2
`define ID_SEL_SECSI 4'h3

// ==========================================================
// Address and data field positions.
`define ADDR_HV_BIT 9
`define SECSI_FACTORY_BIT 7
`define SECSI_CUSTOMER_BIT 6
`define PROT_SET_WORD 16'h0001

// ==========================================================
// Identifier-mode command sequence (address, data).
`define CMD_A1 22'h000555
`define CMD_D1 16'h00AA
`define CMD_A2 22'h0002AA
`define CMD_D2 16'h0055
`define CMD_A3 22'h000555
`define CMD_D3 16'h0090
`define CMD_EXIT 16'h00F0

// ==========================================================
// Timing: bus cycle strobe width and read access, in nanoseconds.
`define T_STROBE_NS 70
`define T_ACCESS_NS 100
`define CLK_NS 50

`endif
